// >>> design/telemetry_word_serial_coupler.sv
// Telemetry word serial coupler: byte FIFO and coupler core
//
// Contract
// - Words go out and come in MSB first, opening with a space start bit.
// - Second word bit picks length: mark gives 32 bits, space gives 16 bits.
// - Host moves words as bytes: two for 16-bit, four for 32-bit words.
// - Received last-byte low five bits read zero on good check, nonzero otherwise.
// - Host zeroes last-byte low five bits; coupler sends generated check segment there.
// - Bit rate follows four switches: 150 to 4800 bit/s.
// - Enabled interrupt when a byte can be sent or a received byte waits.
// - Command bits 0/1: none, enable, disable keeping queue, disarm clearing queue.
// - Command bits 6/7: none, transmit, receive, idle dropping terminal ready.
// - Bit 5 with mode change skips the settling wait; alone it does nothing.
// - Status read gives transmit layout in transmit mode, receive layout otherwise.
// - Overflow sets when an unread received byte is overwritten.
// - Carrier-absent bit is clear with carrier detected, set without.
// - Status bit 3 shows the opposite direction still busy.
// - Receive busy clears when a byte is ready, raising the interrupt.
// - End-of-message flag sets when a 16-bit word matches the end pattern.
// - Status bit 7 mirrors data set ready.
// - Underflow sets when no byte is ready at the next byte period.
// - Status bit 2 in transmit mode is the half-bit phase running at the baud rate.
// - Transmit busy clears when a byte can be taken, setting the interrupt.
// - Attention bit equals the underflow flag.
// - Coupler answers at the switch-selected device address.
`timescale 1ns/1ps
`default_nettype none

module coupler_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0]  wp;
    logic [AW:0]  rp;
    wire          push = in_valid && in_ready;
    wire          pop  = out_valid && out_ready;

    assign in_ready  = (wp - rp) != (AW+1)'(D);
    assign out_valid = wp != rp;
    assign out_data  = mem[rp[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wp <= '0;
            rp <= '0;
        end else begin
            wp <= wp + (AW+1)'(push);
            rp <= rp + (AW+1)'(pop);
        end
    end
endmodule

module telemetry_word_serial_coupler
    import coupler_pkg::*;
#(
    parameter int SETTLE = SETTLE_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire bus_req_s   host_req,
    output logic [7:0]      rdata,
    output logic            rvalid,
    output logic            wready,
    output logic            irq,
    input  wire modem_in_s  modem,
    output logic            txd,
    output logic            dtr,
    output logic            rts,
    input  wire logic [3:0] baud_sw,
    input  wire logic [7:0] addr_sw
);
    // Pin synchronisers: a change counts once the second and third stages agree
    wire [NPIN-1:0] pin_raw = {modem.rxd, modem.dsr, modem.dcd, baud_sw, addr_sw};
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [NPIN-1:0] s3;
    logic [NPIN-1:0] pin;
    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_sync
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    s1[g]  <= PIN_RST[g];
                    s2[g]  <= PIN_RST[g];
                    s3[g]  <= PIN_RST[g];
                    pin[g] <= PIN_RST[g];
                end else begin
                    s1[g] <= pin_raw[g];
                    s2[g] <= s1[g];
                    s3[g] <= s2[g];
                    if (s2[g] == s3[g]) begin
                        pin[g] <= s3[g];
                    end
                end
            end
        end
    endgenerate
    wire       rxd_s = pin[14];
    wire       dsr_s = pin[13];
    wire       dcd_s = pin[12];
    wire [3:0] sw_s  = pin[11:8];
    wire [7:0] adr_s = pin[7:0];

    // Host decode
    wire hit    = host_req.addr == adr_s;
    wire cmd_wr = hit && host_req.cmd_wr;
    wire sts_rd = hit && host_req.sts_rd;
    wire dat_wr = hit && host_req.dat_wr;
    wire dat_rd = hit && host_req.dat_rd;
    wire [7:0] cmd = host_req.wdata;

    mode_e       mode;
    irq_e        int_mode;
    logic        queue;
    logic [16:0] settle;
    logic        overflow_flag;
    logic        underflow_flag;
    logic        message_end_flag;

    // Mode control; settling applies only to a direct TX/RX swap
    wire   want_tx  = cmd_wr && cmd[CMD_TX] && !cmd[CMD_RX];
    wire   want_rx  = cmd_wr && cmd[CMD_RX] && !cmd[CMD_TX];
    wire   want_idl = cmd_wr && cmd[CMD_RX] && cmd[CMD_TX];
    wire   swap     = (want_tx && mode == MODE_RX) || (want_rx && mode == MODE_TX);
    wire   settling = settle != '0;
    mode_e next_mode;
    assign next_mode = want_idl ? MODE_IDLE : want_tx ? MODE_TX : want_rx ? MODE_RX : mode;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mode   <= MODE_IDLE;
            settle <= '0;
        end else begin
            mode <= next_mode;
            if (swap && !cmd[CMD_IMM]) begin
                settle <= 17'(SETTLE);
            end else if (swap || want_idl) begin
                settle <= '0;
            end else if (settling) begin
                settle <= settle - 17'd1;
            end
        end
    end

    // Bit timing: phase toggles each half bit, a transmit bit starts on its fall
    logic [16:0] ph_cnt;
    logic        phase;
    wire  [16:0] half   = half_div(sw_s);
    wire         ph_end = ph_cnt >= half - 17'd1;
    wire         tick   = ph_end && phase;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ph_cnt <= '0;
            phase  <= 1'b0;
        end else begin
            ph_cnt <= ph_end ? '0 : ph_cnt + 17'd1;
            if (ph_end) begin
                phase <= !phase;
            end
        end
    end

    // Transmit byte FIFO
    logic       fifo_valid;
    logic [7:0] fifo_data;
    logic       fifo_ready;
    logic       tx_pop;
    coupler_fifo #(.W(BYTE_W), .D(FIFO_DEPTH)) u_fifo (
        .clk       (ref_clk),
        .rstn      (resetn),
        .in_data   (cmd),
        .in_valid  (dat_wr),
        .in_ready  (fifo_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (tx_pop)
    );
    wire tx_busy = !fifo_ready;

    // Transmitter
    logic       tx_active;
    logic [4:0] tx_pos;
    logic       tx_long;
    logic [7:0] tx_sh;
    logic [4:0] tx_crc;
    wire        need   = tx_pos[2:0] == 3'd0;
    wire        may_go = mode == MODE_TX && !settling;
    wire        load   = tick && need && fifo_valid && (tx_active || may_go);
    wire        starve = tick && need && !fifo_valid && tx_active;
    wire        shift  = load || (tick && !need && tx_active);
    wire [7:0]  cur    = need ? fifo_data : tx_sh;
    wire        long_w = tx_pos == 5'd1 ? cur[7] : tx_long;
    wire        zone   = tx_pos >= (long_w ? 5'(CRC_LONG) : 5'(CRC_SHORT));
    wire        last   = tx_pos == (long_w ? 5'(LAST_LONG) : 5'(LAST_SHORT));
    wire [4:0]  crc_in = tx_pos == 5'd0 ? CRC_INIT : tx_crc;
    wire        data_b = tx_pos == 5'd0 ? 1'b0 : cur[7];
    wire        out_b  = zone ? crc_in[4] : data_b;
    wire [4:0]  crc_nx = zone ? {crc_in[3:0], 1'b0}
                              : {crc_in[3:0], 1'b0} ^ ((crc_in[4] ^ data_b) ? CRC_POLY : 5'h00);
    assign tx_pop = load;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tx_active <= 1'b0;
            tx_pos    <= '0;
            tx_long   <= 1'b0;
            tx_sh     <= '0;
            tx_crc    <= CRC_INIT;
            txd       <= 1'b1;
        end else if (shift) begin
            txd       <= out_b;
            tx_sh     <= {cur[6:0], 1'b0};
            tx_crc    <= crc_nx;
            tx_long   <= long_w;
            tx_active <= !last;
            tx_pos    <= last ? 5'd0 : tx_pos + 5'd1;
        end else if (starve || (tick && !tx_active)) begin
            // An unfed word is abandoned and the line rests at mark
            tx_active <= 1'b0;
            tx_pos    <= '0;
            txd       <= 1'b1;
        end
    end

    // Receiver: samples at mid bit, timed from the start edge
    logic        rx_active;
    logic [16:0] rx_cnt;
    logic        rx_half;
    logic [4:0]  rx_pos;
    logic        rx_long;
    logic [6:0]  rx_sh;
    logic [15:0] rx_raw;
    logic [4:0]  rx_crc;
    logic [7:0]  rx_hold;
    logic        rx_full;
    wire         rx_start = !rx_active && mode == MODE_RX && !settling && !rxd_s;
    wire         smp      = rx_active && rx_cnt == '0 && !rx_half;
    wire         rl_w     = rx_pos == 5'd1 ? rxd_s : rx_long;
    wire         r_zone   = rx_pos >= (rl_w ? 5'(CRC_LONG) : 5'(CRC_SHORT));
    wire         r_last   = rx_pos == (rl_w ? 5'(LAST_LONG) : 5'(LAST_SHORT));
    wire [4:0]   rc_in    = rx_pos == 5'd0 ? CRC_INIT : rx_crc;
    wire         r_bit    = r_zone ? rxd_s ^ rc_in[4] : rxd_s;
    wire [4:0]   rc_nx    = r_zone ? {rc_in[3:0], 1'b0}
                                   : {rc_in[3:0], 1'b0} ^ ((rc_in[4] ^ rxd_s) ? CRC_POLY : 5'h00);
    wire         false_st = smp && rx_pos == 5'd0 && rxd_s;
    wire         byte_end = smp && !false_st && rx_pos[2:0] == 3'd7;
    wire         end16    = smp && r_last && !rl_w && {rx_raw[14:0], rxd_s} == END_PATTERN;
    wire         rx_busy  = !rx_full;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rx_active <= 1'b0;
            rx_cnt    <= '0;
            rx_half   <= 1'b0;
            rx_pos    <= '0;
            rx_long   <= 1'b0;
            rx_sh     <= '0;
            rx_raw    <= '0;
            rx_crc    <= CRC_INIT;
        end else if (rx_start) begin
            // The previous word leaves the half flag set; clear it so sampling stays mid bit
            rx_half   <= 1'b0;
            rx_active <= 1'b1;
            rx_cnt    <= half - 17'd1;
            rx_pos    <= '0;
        end else if (rx_active && rx_cnt != '0) begin
            rx_cnt <= rx_cnt - 17'd1;
        end else if (rx_active && rx_half) begin
            rx_half <= 1'b0;
            rx_cnt  <= half - 17'd1;
        end else if (smp) begin
            rx_half   <= 1'b1;
            rx_cnt    <= half - 17'd1;
            rx_sh     <= {rx_sh[5:0], r_bit};
            rx_raw    <= {rx_raw[14:0], rxd_s};
            rx_crc    <= rc_nx;
            rx_long   <= rl_w;
            rx_active <= !(false_st || r_last);
            rx_pos    <= r_last ? 5'd0 : rx_pos + 5'd1;
        end
    end

    // Holding register, flags and interrupt queue; hardware set wins over clear, except that a disarm command clears the queue
    logic tx_busy_q;
    wire  ev_tx  = tx_busy_q && !tx_busy;
    wire  ev_rx  = byte_end;
    wire  disarm = cmd_wr && cmd[CMD_INT_OFF] && cmd[CMD_INT_ON];

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rx_hold   <= '0;
            rx_full   <= 1'b0;
            overflow_flag    <= 1'b0;
            underflow_flag   <= 1'b0;
            message_end_flag <= 1'b0;
            int_mode  <= INT_DISARMED;
            queue     <= 1'b0;
            tx_busy_q <= 1'b0;
        end else begin
            tx_busy_q <= tx_busy;
            if (byte_end) begin
                rx_hold <= {rx_sh, r_bit};
            end
            rx_full <= byte_end || (rx_full && !dat_rd);
            overflow_flag    <= (byte_end && rx_full && !dat_rd) || (overflow_flag && !sts_rd);
            underflow_flag   <= starve || (underflow_flag && !sts_rd);
            message_end_flag <= end16 || (message_end_flag && !sts_rd);
            if (cmd_wr && cmd[CMD_INT_ON] && !cmd[CMD_INT_OFF]) begin
                int_mode <= INT_ENABLED;
            end else if (cmd_wr && cmd[CMD_INT_OFF] && !cmd[CMD_INT_ON]) begin
                int_mode <= INT_DISABLED;
            end else if (disarm) begin
                int_mode <= INT_DISARMED;
            end
            // A disarm command clears the queue even against a same-cycle event
            if (disarm) begin
                queue <= 1'b0;
            end else if (int_mode != INT_DISARMED && (ev_tx || ev_rx)) begin
                queue <= 1'b1;
            end else if (sts_rd || dat_rd || dat_wr) begin
                queue <= 1'b0;
            end
        end
    end

    // Status layouts
    wire [7:0] st_tx = {dsr_s, 1'b0, underflow_flag, tx_busy, rx_active, phase, 1'b0, underflow_flag};
    wire [7:0] st_rx = {dsr_s, message_end_flag, 1'b0, rx_busy, tx_active, 1'b0, !dcd_s, overflow_flag};
    wire [7:0] st    = mode == MODE_TX ? st_tx : st_rx;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdata  <= '0;
            rvalid <= 1'b0;
            wready <= 1'b0;
            irq    <= 1'b0;
            dtr    <= 1'b0;
            rts    <= 1'b0;
        end else begin
            rvalid <= sts_rd || dat_rd;
            if (sts_rd) begin
                rdata <= st;
            end else if (dat_rd) begin
                rdata <= rx_hold;
            end
            wready <= fifo_ready;
            irq    <= int_mode == INT_ENABLED && queue;
            dtr    <= mode != MODE_IDLE;
            rts    <= mode == MODE_TX;
        end
    end

    AST_DISARM: assert property (@(posedge ref_clk) disable iff (!resetn)
        disarm |=> !queue ##1 !irq) else $error("disarm left interrupt pending");
    AST_IDLE_DTR: assert property (@(posedge ref_clk) disable iff (!resetn)
        want_idl |=> ##1 !dtr) else $error("idle did not drop terminal ready");
    AST_TX_MODE: assert property (@(posedge ref_clk) disable iff (!resetn)
        want_tx |=> mode == MODE_TX ##1 rts) else $error("transmit mode not taken");
    AST_SETTLE: assert property (@(posedge ref_clk) disable iff (!resetn)
        swap && !cmd[CMD_IMM] |=> settling) else $error("turnaround wait skipped");
    AST_ATTN: assert property (@(posedge ref_clk) disable iff (!resetn)
        sts_rd && mode == MODE_TX |=> rvalid && rdata[ST_ATTN] == rdata[ST_FLAG])
        else $error("attention differs from underflow");
    AST_OVERFLOW: assert property (@(posedge ref_clk) disable iff (!resetn)
        byte_end && rx_full && !dat_rd |=> overflow_flag) else $error("overflow missed");
    AST_TX_IRQ: assert property (@(posedge ref_clk) disable iff (!resetn)
        ev_tx && int_mode == INT_ENABLED && !disarm && !cmd_wr |=> queue ##1 irq)
        else $error("transmit ready gave no interrupt");
    AST_START: assert property (@(posedge ref_clk) disable iff (!resetn)
        load && tx_pos == 5'd0 |=> !txd) else $error("start bit not space");
    AST_DSR: assert property (@(posedge ref_clk) disable iff (!resetn)
        sts_rd |=> rdata[ST_DSR] == $past(dsr_s)) else $error("ready bit wrong");
    AST_OTHER_BUSY: assert property (@(posedge ref_clk) disable iff (!resetn)
        sts_rd |=> rdata[ST_OTHER] == $past(mode == MODE_TX ? rx_active : tx_active))
        else $error("opposite direction busy bit wrong");
endmodule

`default_nettype wire

// >>> design/coupler_pkg.sv
// Shared constants and types for the telemetry word serial coupler
package coupler_pkg;
    localparam int          CLK_HZ      = 25_000_000;
    localparam int          CLK_NS      = 40;
    localparam logic [7:0]  ADDR_FIRST  = 8'h8e;
    localparam logic [7:0]  ADDR_SECOND = 8'h8f;
    // Command bit positions
    localparam int CMD_INT_OFF = 0;
    localparam int CMD_INT_ON  = 1;
    localparam int CMD_IMM     = 5;
    localparam int CMD_RX      = 6;
    localparam int CMD_TX      = 7;
    // Status bit positions
    localparam int ST_FLAG     = 0;
    localparam int ST_CARRIER  = 1;
    localparam int ST_PHASE    = 2;
    localparam int ST_OTHER    = 3;
    localparam int ST_BUSY     = 4;
    localparam int ST_ATTN     = 5;
    localparam int ST_MSG_END  = 6;
    localparam int ST_DSR      = 7;
    // Line settling after turnaround
    localparam int SETTLE_MS   = 5;
    localparam int SETTLE_CYC  = SETTLE_MS * (CLK_HZ / 1000);
    // Check segment generator x^5 + x^2 + 1, cleared at each word start
    localparam logic [4:0]  CRC_POLY    = 5'h05;
    localparam logic [4:0]  CRC_INIT    = 5'h00;
    localparam logic [15:0] END_PATTERN = 16'h3ffe;
    localparam int          BYTE_W      = 8;
    localparam int          FIFO_DEPTH  = 16;
    localparam int          LAST_SHORT  = 15;
    localparam int          LAST_LONG   = 31;
    localparam int          CRC_SHORT   = 11;
    localparam int          CRC_LONG    = 27;
    localparam int          NPIN        = 15;
    // Synchroniser reset: data line at mark, address switches at the first unit
    localparam logic [NPIN-1:0] PIN_RST = {3'b100, 4'h0, ADDR_FIRST};

    typedef enum logic [1:0] {MODE_IDLE = 2'b00, MODE_RX = 2'b01, MODE_TX = 2'b10} mode_e;
    typedef enum logic [1:0] {INT_DISARMED = 2'b00, INT_DISABLED = 2'b01, INT_ENABLED = 2'b10} irq_e;

    typedef struct packed {
        logic [7:0] addr;
        logic       cmd_wr;
        logic       sts_rd;
        logic       dat_wr;
        logic       dat_rd;
        logic [7:0] wdata;
    } bus_req_s;

    typedef struct packed {
        logic rxd;
        logic dsr;
        logic dcd;
    } modem_in_s;

    // Half bit period in cycles; codes 7..15 all select 4800 bit/s
    function automatic logic [16:0] half_div(input logic [3:0] sw);
        int d;
        case (sw)
            4'h0:    d = CLK_HZ / 300;
            4'h1:    d = CLK_HZ / 600;
            4'h2:    d = CLK_HZ / 1200;
            4'h3:    d = CLK_HZ / 1800;
            4'h4:    d = CLK_HZ / 2400;
            4'h5:    d = CLK_HZ / 3600;
            4'h6:    d = CLK_HZ / 4800;
            default: d = CLK_HZ / 9600;
        endcase
        return d[16:0];
    endfunction
endpackage

// >>> verif/data_set_model.sv
// Data set stand-in: carrier, ready and received serial data lines
`timescale 1ns/1ps
`default_nettype none

module data_set_model
    import coupler_pkg::*;
#(
    parameter int HALF = 2604
) (
    input  wire logic clk,
    output var modem_in_s modem
);
    initial begin
        modem = '{rxd: 1'b1, dsr: 1'b1, dcd: 1'b1};
    end

    task automatic set_lines(input logic ready, input logic carrier);
        modem.dsr = ready;
        modem.dcd = carrier;
    endtask

    // Caller enters just after a clock edge; the line rests at mark between words
    task automatic send_word(input logic [31:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            modem.rxd = w[i];
            repeat (2 * HALF) @(posedge clk);
        end
        modem.rxd = 1'b1;
    endtask
endmodule

`default_nettype wire

// >>> verif/telemetry_word_serial_coupler_bench.sv
// Self-checking bench for the telemetry word serial coupler
`timescale 1ns/1ps
`default_nettype none

module telemetry_word_serial_coupler_bench
    import coupler_pkg::*;
;
    localparam int HD = CLK_HZ / 9600;
    logic       ref_clk = 1'b0;
    logic       resetn  = 1'b0;
    bus_req_s   host_req = '0;
    logic [7:0] rdata;
    logic       rvalid;
    logic       wready;
    logic       irq;
    modem_in_s  modem;
    logic       txd;
    logic       dtr;
    logic       rts;
    logic [7:0] seen;
    logic [7:0] s1;
    int         n_fail = 0;
    int         n_compared = 0;

    always #(CLK_NS / 2) ref_clk = ~ref_clk;

    telemetry_word_serial_coupler #(.SETTLE(20)) uut (
        .ref_clk(ref_clk), .resetn(resetn), .host_req(host_req), .rdata(rdata), .rvalid(rvalid),
        .wready(wready), .irq(irq), .modem(modem), .txd(txd), .dtr(dtr), .rts(rts),
        .baud_sw(4'h7), .addr_sw(ADDR_SECOND)
    );

    data_set_model #(.HALF(HD)) model (.clk(ref_clk), .modem(modem));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic put(input logic cmd, input logic [7:0] b);
        @(posedge ref_clk);
        #1;
        host_req = '{addr: ADDR_SECOND, cmd_wr: cmd, sts_rd: 1'b0, dat_wr: ~cmd, dat_rd: 1'b0, wdata: b};
        @(posedge ref_clk);
        #1;
        host_req = '0;
    endtask

    // Read strobe; the one-cycle answer is looked at in the cycle after the strobe is taken
    task automatic get(input logic [7:0] a, input logic sts, output logic [7:0] b);
        @(posedge ref_clk);
        #1;
        host_req = '{addr: a, cmd_wr: 1'b0, sts_rd: sts, dat_wr: 1'b0, dat_rd: ~sts, wdata: 8'h00};
        @(posedge ref_clk);
        #1;
        host_req = '0;
        chk({7'h00, rvalid}, {7'h00, a == ADDR_SECOND});
        b = rdata;
    endtask

    task automatic t_reset_idle();
        chk({4'h0, txd, dtr, rts, irq}, 8'h08);
        get(ADDR_SECOND, 1'b1, seen);
        chk(seen, 8'h90);
        model.set_lines(1'b0, 1'b0);
        cycles(6);
        get(ADDR_SECOND, 1'b1, seen);
        chk(seen, 8'h12);
        model.set_lines(1'b1, 1'b1);
        cycles(6);
        get(ADDR_SECOND, 1'b1, seen);
        chk(seen, 8'h90);
    endtask

    task automatic t_address();
        get(ADDR_FIRST, 1'b1, seen);
    endtask

    // Fill the byte buffer until it refuses, then empty it with a mid-run reset
    task automatic t_fifo_fill();
        for (int i = 0; i < FIFO_DEPTH; i++)
            put(1'b0, 8'(i));
        cycles(2);
        chk({7'h00, wready}, 8'h00);
        put(1'b0, 8'hff);
        resetn = 1'b0;
        cycles(2);
        resetn = 1'b1;
        cycles(8);
        chk({7'h00, wready}, 8'h01);
    endtask

    task automatic t_transmit();
        int k;
        put(1'b0, 8'h2d);
        put(1'b1, 8'h80);
        cycles(3);
        chk({6'h00, dtr, rts}, 8'h03);
        k = 0;
        while (txd !== 1'b0 && k < 6 * HD) begin
            cycles(1);
            k++;
        end
        cycles(HD);
        for (int i = 7; i >= 0; i--) begin
            seen[i] = txd;
            cycles(2 * HD);
        end
        chk(seen, 8'h2d);
        chk({7'h00, txd}, 8'h01);
        get(ADDR_SECOND, 1'b1, seen);
        chk(seen & 8'hfb, 8'ha1);
        s1 = seen;
        cycles(HD - 2);
        get(ADDR_SECOND, 1'b1, seen);
        chk(seen & 8'hfb, 8'h80);
        chk({7'h00, seen[ST_PHASE]}, {7'h00, ~s1[ST_PHASE]});
    endtask

    task automatic t_receive();
        put(1'b1, 8'h41);
        cycles(30);
        fork
            model.send_word(32'h0000_3500, 16);
        join_none
        cycles(16 * HD);
        chk({7'h00, irq}, 8'h00);
        put(1'b1, 8'h02);
        cycles(2);
        chk({7'h00, irq}, 8'h01);
        // Disarm while the request is still pending, so the drop is its doing
        put(1'b1, 8'h03);
        cycles(2);
        chk({7'h00, irq}, 8'h00);
        get(ADDR_SECOND, 1'b1, seen);
        chk(seen, 8'h80);
        get(ADDR_SECOND, 1'b0, seen);
        chk(seen, 8'h35);
        put(1'b1, 8'hc0);
        cycles(3);
        chk({6'h00, dtr, rts}, 8'h00);
    endtask

    initial begin
        cycles(4);
        resetn = 1'b1;
        cycles(8);
        t_reset_idle();
        t_address();
        t_fifo_fill();
        t_transmit();
        t_receive();
        summarize();
    end

    // Whole run is at most about 94k cycles; a hang is cut at 100k
    initial begin
        repeat (100000) @(posedge ref_clk);
        n_fail++;
        summarize();
    end
endmodule

`default_nettype wire
